/* phy_polarity_bypass_pkg.sv */
// Constants shared by the PHY polarity and bypass control block.
package phy_polarity_bypass_pkg;

    // ------------------------------------------------------------
    // Register field layout
    // ------------------------------------------------------------
    localparam int unsigned reg_width = 16;
    localparam int unsigned bit_rx_clock_gating = 0;
    localparam int unsigned bit_coding_bypass = 1;
    localparam int unsigned bit_rx_polarity = 4;
    localparam int unsigned bit_auto_polarity_disable = 5;
    localparam int unsigned bit_heartbeat_inhibit = 11;
    localparam int unsigned bit_natural_loop = 10;
    localparam logic [15:0] writable_mask = 16'h0c33;
    localparam logic [15:0] reserved_value = 16'h0140;
    localparam logic [15:0] ctrl_reset = 16'h0140;

    // ------------------------------------------------------------
    // Polarity detection
    // ------------------------------------------------------------
    localparam int unsigned reversed_pulse_count = 3;
    localparam logic [1:0] reversed_count_max = 2'h3;

    typedef enum logic [2:0] {
        pol_normal = 3'b001,
        pol_suspect = 3'b010,
        pol_inverted = 3'b100
    } pol_state_t;

endpackage

/* rx_polarity_detect.sv */
// Automatic receive polarity detector for the 10 Mb/s path.
`timescale 1ns/1ps
module rx_polarity_detect
    import phy_polarity_bypass_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic autoneg_active,
    input wire logic pulse_seen,
    input wire logic pulse_reversed,
    output logic inverting
);
    pol_state_t state;
    logic [1:0] hits;

    // ------------------------------------------------------------
    // Detection state
    // ------------------------------------------------------------
    // A single reversed pulse may be noise, so several in a row are needed.
    always_ff @(posedge sys_clk) begin
        if (rst || !enable) begin
            state <= pol_normal;
            hits <= 2'h0;
        end else if (autoneg_active && pulse_seen) begin
            unique case (state)
                pol_normal: begin
                    if (pulse_reversed) begin
                        state <= pol_suspect;
                        hits <= 2'h1;
                    end
                end
                pol_suspect: begin
                    if (!pulse_reversed) begin
                        state <= pol_normal;
                        hits <= 2'h0;
                    end else if (hits == reversed_count_max - 2'h1) begin
                        state <= pol_inverted;
                    end else begin
                        hits <= hits + 2'h1;
                    end
                end
                pol_inverted: begin
                    state <= pol_inverted;
                end
                default: begin
                    state <= pol_normal;
                end
            endcase
        end
    end

    assign inverting = (state == pol_inverted);

endmodule // rx_polarity_detect

/* phy_polarity_bypass_ctrl.sv */
// Lower control bits of the PHY vendor-specific management register.
`timescale 1ns/1ps
module phy_polarity_bypass_ctrl
    import phy_polarity_bypass_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic reg_write,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    input wire logic speed_100,
    input wire logic autoneg_enable,
    input wire logic autoneg_active,
    input wire logic basic_loopback_enable,
    input wire logic rx_pulse_seen,
    input wire logic rx_pulse_reversed,
    input wire logic rx_data_valid,
    output logic auto_polarity_disable,
    output logic receive_polarity_invert,
    output logic coding_sublayer_bypass,
    output logic receive_clock_gating_enable,
    output logic heartbeat_test_inhibit,
    output logic natural_loop_10m,
    output logic rx_invert_active,
    output logic bypass_active,
    output logic rx_clock_stop
);
    import phy_polarity_bypass_pkg::*;

    logic [15:0] ctrl;
    logic auto_inverting;
    logic next_invert;
    logic gating_allowed;
    logic detect_enable;
    logic next_bypass;
    logic next_clock_stop;

    // ------------------------------------------------------------
    // Auto polarity
    // ------------------------------------------------------------
    // The detector is held cleared while disabled, so it always restarts from normal.
    // detector gate
    assign detect_enable = !ctrl[bit_auto_polarity_disable] && !speed_100;

    rx_polarity_detect u_detect (
        .sys_clk(sys_clk),
        .rst(rst),
        .enable(detect_enable),
        .autoneg_active(autoneg_active),
        .pulse_seen(rx_pulse_seen),
        .pulse_reversed(rx_pulse_reversed),
        .inverting(auto_inverting)
    );

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    // writes masked
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl <= ctrl_reset;
        end else if (reg_write) begin
            ctrl <= (reg_wdata & writable_mask) | reserved_value;
        end
    end

    // ------------------------------------------------------------
    // Effective receive polarity
    // ------------------------------------------------------------
    always_comb begin
        if (ctrl[bit_auto_polarity_disable]) begin
            next_invert = ctrl[bit_rx_polarity];
        end else begin
            next_invert = auto_inverting;
        end
    end

    // Loopback wins over the gating bit, since looped data would otherwise lose its clock.
    // loopback stops gating
    assign gating_allowed = speed_100 && !basic_loopback_enable;

    // ------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------
    // The bypass is not checked against the negotiation setting; software
    // keeps that pairing, so a wrong setting reaches the data path as written.
    // bypass in 100M
    assign next_bypass = ctrl[bit_coding_bypass] && speed_100;

    assign next_clock_stop = ctrl[bit_rx_clock_gating] && gating_allowed && !rx_data_valid;

    // ------------------------------------------------------------
    // Readback
    // ------------------------------------------------------------
    // Bit 4 reads the polarity in force rather than the stored bit, so
    // software sees what the receiver really does.
    function automatic logic [15:0] readback_word(
        input logic [15:0] word,
        input logic polarity
    );
        return {word[15:5], polarity, word[3:0]};
    endfunction

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= ctrl_reset;
        end else begin
            reg_rdata <= readback_word(ctrl, next_invert);
        end
    end

    // ------------------------------------------------------------
    // Data path controls
    // ------------------------------------------------------------
    // Each control is registered so that every pin comes straight from a flip-flop.
    // polarity in force
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rx_invert_active <= 1'b0;
        end else begin
            rx_invert_active <= next_invert;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bypass_active <= 1'b0;
        end else begin
            bypass_active <= next_bypass;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rx_clock_stop <= 1'b0;
        end else begin
            rx_clock_stop <= next_clock_stop;
        end
    end

    // ------------------------------------------------------------
    // Field copies
    // ------------------------------------------------------------
    // Each writable bit except bit 4 is mirrored on its own pin one clock after it is written; bit 4's pin carries the polarity in force.
    // disable bit copy
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            auto_polarity_disable <= 1'b0;
        end else begin
            auto_polarity_disable <= ctrl[bit_auto_polarity_disable];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            receive_polarity_invert <= 1'b0;
        end else begin
            receive_polarity_invert <= next_invert;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            coding_sublayer_bypass <= 1'b0;
        end else begin
            coding_sublayer_bypass <= ctrl[bit_coding_bypass];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            receive_clock_gating_enable <= 1'b0;
        end else begin
            receive_clock_gating_enable <= ctrl[bit_rx_clock_gating];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            heartbeat_test_inhibit <= 1'b0;
        end else begin
            heartbeat_test_inhibit <= ctrl[bit_heartbeat_inhibit];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            natural_loop_10m <= 1'b0;
        end else begin
            natural_loop_10m <= ctrl[bit_natural_loop];
        end
    end

endmodule // phy_polarity_bypass_ctrl

/* phy_polarity_bypass_asserts.sv */
// Port checks for the polarity and bypass control block.
`timescale 1ns/1ps
module phy_polarity_bypass_asserts (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic reg_write,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic speed_100,
    input wire logic basic_loopback_enable,
    input wire logic rx_data_valid,
    input wire logic auto_polarity_disable,
    input wire logic receive_polarity_invert,
    input wire logic coding_sublayer_bypass,
    input wire logic receive_clock_gating_enable,
    input wire logic rx_invert_active,
    input wire logic bypass_active,
    input wire logic rx_clock_stop
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_write_lands: assert property (reg_write |-> ##2
        (reg_rdata & 16'h0c23) == ($past(reg_wdata, 2) & 16'h0c23)) else $error("write lost");
    a_reserved_fixed: assert property ((reg_rdata & 16'hf3cc) == 16'h0140)
        else $error("reserved bits wrong");
    a_rdata_fields: assert property (reg_rdata[5:4] == {auto_polarity_disable,
        receive_polarity_invert} && reg_rdata[1] == coding_sublayer_bypass) else $error("fields");
    a_pol_status: assert property (rx_invert_active == receive_polarity_invert)
        else $error("polarity status differs");
    a_forced_pol: assert property (reg_write && reg_wdata[5] |-> ##2
        rx_invert_active == $past(reg_wdata[4], 2)) else $error("forced polarity");
    a_no_auto: assert property (auto_polarity_disable && !$past(reg_write) &&
        !$past(reg_write, 2) |-> $stable(rx_invert_active)) else $error("auto correction");
    a_auto_invert: assert property ($rose(rx_invert_active) && !auto_polarity_disable
        |-> !$past(speed_100, 2)) else $error("auto invert at 100");
    a_bypass_map: assert property (bypass_active == (coding_sublayer_bypass &&
        $past(speed_100))) else $error("bypass");
    a_clock_gate: assert property (rx_clock_stop == (receive_clock_gating_enable &&
        $past(speed_100 && !basic_loopback_enable && !rx_data_valid))) else $error("gating");
    cover property (rx_clock_stop);
    cover property ($rose(rx_invert_active) && !auto_polarity_disable);
    cover property (bypass_active);
endmodule // phy_polarity_bypass_asserts

/* mgmt_write_model.sv */
// Management-side model that issues register writes.
`timescale 1ns/1ps
module mgmt_write_model
    import phy_polarity_bypass_pkg::*;
(
    input wire logic req,
    input wire logic raw,
    input wire logic [15:0] req_data,
    input wire logic [15:0] reg_rdata,
    input wire logic speed_100,
    input wire logic autoneg_enable,
    output logic reg_write,
    output logic [15:0] reg_wdata
);
    // Raw mode skips the courtesy rules, so refusal paths get exercised.
    always_comb begin
        reg_write = req;
        reg_wdata = raw ? req_data : (req_data & writable_mask) | (reg_rdata & ~writable_mask);
        if (!raw && (!speed_100 || autoneg_enable)) reg_wdata[1] = 1'b0;
        if (!raw && reg_wdata[1]) reg_wdata[0] = 1'b0;
    end
endmodule // mgmt_write_model

/* phy_polarity_bypass_ctrl_tb.sv */
// Self-checking bench for the polarity and bypass control block.
`timescale 1ns/1ps
module phy_polarity_bypass_ctrl_tb;
    import phy_polarity_bypass_pkg::*;
    logic sys_clk = 0, rst = 1, req = 0, raw = 0, reg_write, speed_100 = 0, autoneg_enable = 0;
    logic autoneg_active = 0, basic_loopback_enable = 0, rx_pulse_seen = 0, rx_pulse_reversed = 0;
    logic rx_data_valid = 0, auto_polarity_disable, receive_polarity_invert, coding_sublayer_bypass;
    logic receive_clock_gating_enable, heartbeat_test_inhibit, natural_loop_10m, rx_invert_active;
    logic bypass_active, rx_clock_stop;
    logic [15:0] req_data = 16'h0000, reg_wdata, reg_rdata, ctrl = 16'h0000;
    logic [31:0] seed = 32'h0000005e;
    int error_cnt = 0, tests_run = 0, det = 0, run = 0;
    phy_polarity_bypass_ctrl phy_polarity_bypass_ctrl_i (.*);
    mgmt_write_model mgmt_write_model_i (.*);
    initial forever #4 sys_clk = ~sys_clk;
    function automatic logic [31:0] xs(logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic check(logic [15:0] seen, logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic check_all();
        logic p;
        @(negedge sys_clk);
        if (ctrl[5] || speed_100) det = 0;
        p = ctrl[5] ? ctrl[4] : det[0];
        check(reg_rdata, (ctrl & 16'h0c23) | 16'h0140 | {11'h0, p, 4'h0});
        check({13'h0, rx_invert_active, bypass_active, rx_clock_stop}, {13'h0, p,
            ctrl[1] & speed_100, ctrl[0] & speed_100 & ~basic_loopback_enable & ~rx_data_valid});
        check({10'h0, heartbeat_test_inhibit, natural_loop_10m, auto_polarity_disable,
            receive_polarity_invert, coding_sublayer_bypass, receive_clock_gating_enable},
            {10'h0, ctrl[11], ctrl[10], ctrl[5], p, ctrl[1], ctrl[0]});
    endtask
    task automatic wr(logic [15:0] v, logic r);
        @(negedge sys_clk);
        req = 1;
        req_data = v;
        raw = r;
        if (!r && (!speed_100 || autoneg_enable)) v[1] = 0;
        if (!r && v[1]) v[0] = 0;
        ctrl = v & writable_mask;
        @(negedge sys_clk);
        req = 0;
        check_all();
    endtask
    task automatic pulse(logic r);
        @(negedge sys_clk);
        rx_pulse_seen = 1;
        rx_pulse_reversed = r;
        run = r ? run + 1 : 0;
        if (run >= reversed_pulse_count) det = 1;
        @(negedge sys_clk);
        rx_pulse_seen = 0;
        check_all();
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #100000;
        error_cnt++;
        complete_run();
    end
    initial begin
        repeat (6) @(negedge sys_clk);
        rst = 0;
        check_all();
        for (int i = 0; i < 24; i++) begin
            seed = xs(seed);
            speed_100 = seed[16];
            autoneg_enable = seed[17];
            wr(seed[15:0], seed[18]);
        end
        $display("test random done");
        speed_100 = 1;
        autoneg_enable = 0;
        wr(16'h0001, 0);
        for (int i = 0; i < 4; i++) begin
            {rx_data_valid, basic_loopback_enable} = 2'(i);
            check_all();
        end
        $display("test gating done");
        speed_100 = 0;
        autoneg_active = 1;
        wr(16'h0000, 0);
        for (int i = 6; i >= 0; i--) pulse(1'(7'h6e >> i));
        wr(16'h0020, 0);
        wr(16'h0030, 0);
        wr(16'h0000, 0);
        for (int i = 0; i < 3; i++) pulse(1'b1);
        speed_100 = 1;
        @(negedge sys_clk);
        check_all();
        $display("test polarity done");
        complete_run();
    end
endmodule // phy_polarity_bypass_ctrl_tb
bind phy_polarity_bypass_ctrl phy_polarity_bypass_asserts phy_polarity_bypass_asserts_i (.*);
